//--- design/muldiv_core.sv
// combinational unsigned 8x8 multiply and 16/8 divide
`timescale 1ns/100ps
`default_nettype none
module muldiv_core
  import muldiv_pkg::*;
(
  // operands
  input  wire logic       divide,
  input  wire logic [7:0] opb,
  input  wire logic [7:0] rlo,
  input  wire logic [7:0] rhi,
  // results
  output logic      [7:0] new_lo,
  output logic      [7:0] new_hi,
  output logic            neg,
  output logic            ovf,
  output logic            zero
);
  logic [15:0] product;
  logic [15:0] dividend;
  logic [15:0] quot;
  logic [15:0] remd;

  // arithmetic; divide by zero counts as overflow
  always_comb
  begin
    product  = {8'h00, rlo} * {8'h00, opb};
    dividend = {rhi, rlo};
    quot     = (opb == 8'h00) ? 16'hffff : dividend / {8'h00, opb};
    remd     = (opb == 8'h00) ? dividend : dividend % {8'h00, opb};
    if (!divide)
    begin
      new_lo = product[7:0];
      new_hi = product[15:8];
      neg    = product[15];
      ovf    = 1'b0;
      zero   = (product == 16'h0000);
    end
    else
    begin
      ovf = (quot[15:8] != 8'h00);
      if (ovf)
      begin
        new_lo = rlo;
        new_hi = rhi;
      end
      else
      begin
        new_lo = quot[7:0];
        new_hi = remd[7:0];
      end
      neg  = new_lo[7];
      zero = (new_lo == 8'h00);
    end
  end
endmodule : muldiv_core
`default_nettype wire

//--- design/muldiv_pkg.sv
// constants and register map of the nibble-mapped multiply/divide unit
// What this block does
// - multiply or divide completes exactly 10 clock cycles after the start write
// - operand_b is two nibble addresses and keeps its value until rewritten
// - result_lo is two nibble addresses, low first, captured at start
// - result_lo gets product low byte or quotient at completion
// - result_hi ignored at multiply start, then loaded with product high byte
// - result_hi captured as dividend high at divide start, then gets remainder
// - divide overflow leaves both result bytes holding the dividend
// - bit 3 of control nibble is negative flag, the result MSB
// - bit 2 is divide overflow flag, always cleared after multiply
// - bit 1 is zero flag, set when result is zero
// - flags are read-only and cleared by reset
// - writing bit 0 starts operation: 1 divide, 0 multiply
// - bit 0 reads 1 while running, 0 when finished, 0 at reset
// - operand and result registers are not initialised by reset
// - multiply: negative from result_hi MSB, zero when 16-bit product is zero
// - divide: negative from result_lo MSB, zero when result_lo is zero
// - overflow set when unsigned quotient does not fit in 8 bits
package muldiv_pkg;
  localparam logic [15:0] ADDR_OPB_LO  = 16'hff80;
  localparam logic [15:0] ADDR_OPB_HI  = 16'hff81;
  localparam logic [15:0] ADDR_RLO_LO  = 16'hff82;
  localparam logic [15:0] ADDR_RLO_HI  = 16'hff83;
  localparam logic [15:0] ADDR_RHI_LO  = 16'hff84;
  localparam logic [15:0] ADDR_RHI_HI  = 16'hff85;
  localparam logic [15:0] ADDR_CTRL    = 16'hff86;
  localparam int          BIT_NEG      = 3;
  localparam int          BIT_OVF      = 2;
  localparam int          BIT_ZERO     = 1;
  localparam int          BIT_START    = 0;
  localparam logic [3:0]  CTRL_RESET   = 4'h0;
  localparam int          CLK_MHZ      = 100;
  localparam int          OP_CYCLES    = 10;
  localparam logic [3:0]  OP_LAST      = 4'(OP_CYCLES - 1);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } op_state_e;
endpackage : muldiv_pkg

//--- design/muldiv_unit.sv
// nibble-mapped multiply/divide unit on the cpu i/o bus
`timescale 1ns/100ps
`default_nettype none
module muldiv_unit
  import muldiv_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // i/o memory bus
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [3:0]  bus_wdata,
  output logic      [3:0]  bus_rdata,
  output logic             bus_sel
);
  logic [7:0] opb_q;
  logic [7:0] rlo_q;
  logic [7:0] rhi_q;
  logic [7:0] s_opb_q;
  logic [7:0] s_lo_q;
  logic [7:0] s_hi_q;
  logic       s_div_q;
  logic       neg_q;
  logic       ovf_q;
  logic       zero_q;
  logic [3:0] cnt_q;
  logic       done;
  logic       start;
  logic [7:0] new_lo;
  logic [7:0] new_hi;
  logic       c_neg;
  logic       c_ovf;
  logic       c_zero;
  op_state_e  state_q;

  //////////////////////////////////////////////////////////////////////////
  // decode
  assign start = bus_wr && (bus_addr == ADDR_CTRL);
  assign done  = (state_q == ST_RUN) && (cnt_q == OP_LAST);
  assign bus_sel = (bus_addr >= ADDR_OPB_LO) && (bus_addr <= ADDR_CTRL);

  //////////////////////////////////////////////////////////////////////////
  // sequencer: run for a fixed count, a new start restarts it
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
    end
    else if (start)
    begin
      state_q <= ST_RUN;
      cnt_q   <= 4'h0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          cnt_q <= 4'h0;
        end
        ST_RUN:
        begin
          if (done)
          begin
            state_q <= ST_IDLE;
          end
          cnt_q <= cnt_q + 4'h1;
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // operand snapshot at the start write
  always_ff @(posedge clk_sys)
  begin
    if (start)
    begin
      s_opb_q <= opb_q;
      s_lo_q  <= rlo_q;
      s_hi_q  <= rhi_q;
      s_div_q <= bus_wdata[BIT_START];
    end
  end

  muldiv_core u_core (
    .divide (s_div_q),
    .opb    (s_opb_q),
    .rlo    (s_lo_q),
    .rhi    (s_hi_q),
    .new_lo (new_lo),
    .new_hi (new_hi),
    .neg    (c_neg),
    .ovf    (c_ovf),
    .zero   (c_zero)
  );

  //////////////////////////////////////////////////////////////////////////
  // operand register, no reset
  always_ff @(posedge clk_sys)
  begin
    if (bus_wr && bus_addr == ADDR_OPB_LO)
    begin
      opb_q[3:0] <= bus_wdata;
    end
    if (bus_wr && bus_addr == ADDR_OPB_HI)
    begin
      opb_q[7:4] <= bus_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // result registers: completion beats a colliding result write, a colliding start write cancels it
  always_ff @(posedge clk_sys)
  begin
    if (done && !start)
    begin
      rlo_q <= new_lo;
      rhi_q <= new_hi;
    end
    else if (bus_wr)
    begin
      if (bus_addr == ADDR_RLO_LO)
      begin
        rlo_q[3:0] <= bus_wdata;
      end
      if (bus_addr == ADDR_RLO_HI)
      begin
        rlo_q[7:4] <= bus_wdata;
      end
      if (bus_addr == ADDR_RHI_LO)
      begin
        rhi_q[3:0] <= bus_wdata;
      end
      if (bus_addr == ADDR_RHI_HI)
      begin
        rhi_q[7:4] <= bus_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // flags, read-only, updated with the results
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      neg_q  <= CTRL_RESET[BIT_NEG];
      ovf_q  <= CTRL_RESET[BIT_OVF];
      zero_q <= CTRL_RESET[BIT_ZERO];
    end
    else if (done && !start)
    begin
      neg_q  <= c_neg;
      ovf_q  <= c_ovf;
      zero_q <= c_zero;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data, registered, one cycle after the read strobe
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      bus_rdata <= 4'h0;
    end
    else if (bus_rd)
    begin
      unique case (bus_addr)
        ADDR_OPB_LO: bus_rdata <= opb_q[3:0];
        ADDR_OPB_HI: bus_rdata <= opb_q[7:4];
        ADDR_RLO_LO: bus_rdata <= rlo_q[3:0];
        ADDR_RLO_HI: bus_rdata <= rlo_q[7:4];
        ADDR_RHI_LO: bus_rdata <= rhi_q[3:0];
        ADDR_RHI_HI: bus_rdata <= rhi_q[7:4];
        ADDR_CTRL:   bus_rdata <= {neg_q, ovf_q, zero_q, state_q == ST_RUN};
        default:     bus_rdata <= 4'h0;
      endcase
    end
    else
    begin
      bus_rdata <= 4'h0;
    end
  end
endmodule : muldiv_unit
`default_nettype wire

//--- verification/cpu_bus_model.sv
// cpu-side bus master model for the multiply/divide unit
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model
  import muldiv_pkg::*;
(
  // clock
  input  wire logic        clk_sys,
  // i/o bus
  output logic      [15:0] bus_addr,
  output logic             bus_wr,
  output logic             bus_rd,
  output logic      [3:0]  bus_wdata,
  input  wire logic [3:0]  bus_rdata
);
  // idle bus at time zero
  initial
  begin
    bus_addr = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 4'h0;
  end
  // one write, held through the taking edge
  task automatic wr(input logic [15:0] a, input logic [3:0] d);
    @(posedge clk_sys) #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge clk_sys) #1;
    bus_wr = 1'b0;
    bus_wdata = ~d;
  endtask : wr
  // one read, data taken after the taking edge
  task automatic rd(input logic [15:0] a, output logic [3:0] d);
    @(posedge clk_sys) #1;
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge clk_sys) #1;
    bus_rd = 1'b0;
    d = bus_rdata;
  endtask : rd
  // keep off results and flags until the operation ends
  task automatic settle;
    repeat (OP_CYCLES) @(posedge clk_sys);
  endtask : settle
endmodule : cpu_bus_model
`default_nettype wire

//--- verification/muldiv_unit_asserts.sv
// bus-level assertions for the multiply/divide unit
`timescale 1ns/100ps
`default_nettype none
module muldiv_unit_asserts
  import muldiv_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // i/o bus
  input wire logic [15:0] bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [3:0]  bus_wdata,
  input wire logic [3:0]  bus_rdata,
  input wire logic        bus_sel
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [7:0] since_q;
  logic [7:0] opb_q;
  logic       div_q;
  logic       ran_q;
  sequence s_start;
    bus_wr && bus_addr == ADDR_CTRL;
  endsequence
  sequence s_rd_ctrl;
    bus_rd && bus_addr == ADDR_CTRL;
  endsequence
  // edges since the last start write, saturating
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) since_q <= 8'hff;
    else if (bus_wr && bus_addr == ADDR_CTRL) since_q <= 8'h01;
    else if (since_q != 8'hff) since_q <= since_q + 8'h01;
  end
  // mode of the last start and operand_b shadow
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) ran_q <= 1'b0;
    else if (bus_wr && bus_addr == ADDR_CTRL) ran_q <= 1'b1;
    if (bus_wr && bus_addr == ADDR_CTRL) div_q <= bus_wdata[0];
    if (bus_wr && bus_addr == ADDR_OPB_LO) opb_q[3:0] <= bus_wdata;
    if (bus_wr && bus_addr == ADDR_OPB_HI) opb_q[7:4] <= bus_wdata;
  end
  busy_hold_a: assert property (s_rd_ctrl ##0 since_q inside {[1:9]} |=> bus_rdata[0])
    else $error("busy bit low during run");
  done_clear_a: assert property (s_rd_ctrl ##0 (ran_q && since_q > 8'd10) |=> !bus_rdata[0])
    else $error("busy bit high after ten cycles");
  mul_ovf_a: assert property (s_rd_ctrl ##0 (!div_q && since_q > 8'd10) |=> !bus_rdata[2])
    else $error("overflow set after multiply");
  reset_flags_a: assert property (s_rd_ctrl ##0 !ran_q |=> bus_rdata == CTRL_RESET)
    else $error("control nibble not clear after reset");
  opb_low_a: assert property (bus_rd && bus_addr == ADDR_OPB_LO |=> bus_rdata == opb_q[3:0])
    else $error("operand low nibble lost");
  opb_high_a: assert property (bus_rd && bus_addr == ADDR_OPB_HI |=> bus_rdata == opb_q[7:4])
    else $error("operand high nibble lost");
  sel_decode_a: assert property (bus_sel == (bus_addr >= ADDR_OPB_LO && bus_addr <= ADDR_CTRL))
    else $error("select decode wrong");
  unmapped_zero_a: assert property (bus_rd && !bus_sel |=> bus_rdata == 4'h0)
    else $error("unmapped read not zero");
endmodule : muldiv_unit_asserts
bind muldiv_unit muldiv_unit_asserts u_chk (.clk_sys, .rst_n, .bus_addr, .bus_wr, .bus_rd,
  .bus_wdata, .bus_rdata, .bus_sel);
`default_nettype wire

//--- verification/muldiv_unit_tb.sv
// self-checking testbench for the multiply/divide unit
`timescale 1ns/100ps
`default_nettype none
module muldiv_unit_tb
  import muldiv_pkg::*;
();
  logic        clk_sys;
  logic        rst_n;
  logic [15:0] bus_addr;
  logic        bus_wr;
  logic        bus_rd;
  logic [3:0]  bus_wdata;
  logic [3:0]  bus_rdata;
  logic        bus_sel;
  logic [3:0]  got;
  logic [7:0]  opb_last;
  logic [47:0] e;
  int          n_fail;
  int          samples_checked;
  // {div, operand_b, dividend hi, lo, expected hi, lo, flags}
  logic [47:0] ops [9] = '{48'h0_64_ff_00_00_00_2, 48'h0_58_ff_64_22_60_0, 48'h0_58_ff_c8_44_c0_0,
    48'h1_64_1a_16_4e_42_0, 48'h1_64_33_2c_00_83_8, 48'h1_13_24_e8_24_e8_c, 48'h1_13_11_68_0a_ea_8,
    48'h0_a5_00_c8_80_e8_8, 48'h1_58_00_00_00_00_2};
  muldiv_unit dut (.clk_sys, .rst_n, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .bus_sel);
  cpu_bus_model cpu (.clk_sys, .bus_addr, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata);
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    samples_checked++;
    if (g !== x)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic wrap_up;
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  // clock and hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial
  begin
    #200000;
    n_fail++;
    wrap_up();
  end
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    opb_last = 8'h00;
    repeat (12) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    cpu.rd(ADDR_CTRL, got);
    chk(got, CTRL_RESET);
    foreach (ops[i])
    begin
      e = ops[i];
      if (e[43:36] !== opb_last)
      begin
        cpu.wr(ADDR_OPB_LO, e[39:36]);
        cpu.wr(ADDR_OPB_HI, e[43:40]);
      end
      opb_last = e[43:36];
      for (int k = 0; k < 4; k++)
        cpu.wr(16'(ADDR_RLO_LO + k), e[20+4*k +: 4]);
      cpu.wr(ADDR_CTRL, {3'b111, e[44]});
      cpu.rd(ADDR_CTRL, got);
      chk(got[0], 1'b1);
      cpu.settle();
      cpu.rd(ADDR_CTRL, got);
      chk(got, e[3:0]);
      for (int k = 0; k < 4; k++)
      begin
        cpu.rd(16'(ADDR_RLO_LO + k), got);
        chk(got, e[4+4*k +: 4]);
      end
    end
    // reset in mid-run clears busy and the zero flag left by the last divide
    cpu.wr(ADDR_CTRL, 4'h1);
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    cpu.rd(ADDR_CTRL, got);
    chk(got, CTRL_RESET);
    // a result write during the run must not disturb the snapshot
    cpu.wr(ADDR_RLO_LO, 4'h4);
    cpu.wr(ADDR_RLO_HI, 4'h6);
    cpu.wr(ADDR_CTRL, 4'h0);
    cpu.wr(ADDR_RLO_LO, 4'hf);
    cpu.settle();
    cpu.rd(ADDR_CTRL, got);
    chk(got, 4'h0);
    e = 48'h2260;
    for (int k = 0; k < 4; k++)
    begin
      cpu.rd(16'(ADDR_RLO_LO + k), got);
      chk(got, e[4*k +: 4]);
    end
    cpu.rd(ADDR_OPB_LO, got);
    chk(got, 4'h8);
    cpu.rd(ADDR_OPB_HI, got);
    chk(got, 4'h5);
    chk(bus_sel, 1'b1);
    cpu.rd(16'hff87, got);
    chk(got, 4'h0);
    chk(bus_sel, 1'b0);
    wrap_up();
  end
endmodule : muldiv_unit_tb
`default_nettype wire
